// *** verilog/rstr_pkg.sv ***
// Package for the return stack, status flag and table read block.
// Assumes a single 50 MHz core clock with synchronous active-low reset.
package rstr_pkg;

   // Program counter and stack geometry.
   localparam int PC_W = 12;
   localparam int STK_DEPTH = 6;
   localparam int LVL_W = 3;
   localparam logic [LVL_W-1:0] LVL_EMPTY = 3'h0;
   localparam logic [LVL_W-1:0] LVL_FULL = 3'h6;
   localparam logic [PC_W-1:0] PC_RESET = 12'h000;

   // Program memory geometry: 4K words of 16 bits, pages of 256 words.
   localparam int WORD_W = 16;
   localparam int PAGE_W = 4;
   localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hf;

   // Status flag bit positions.
   localparam int FLG_W = 4;
   localparam int FLG_C = 0;
   localparam int FLG_AC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam logic [FLG_W-1:0] FLG_RESET = 4'h0;

   // Serial programming frame lengths in bits.
   localparam logic [4:0] PRG_RD_BITS = 5'h0d;
   localparam logic [4:0] PRG_WR_BITS = 5'h1d;
   localparam logic [4:0] PRG_OUT_BITS = 5'h10;

   // Kinds of ALU operation that touch the flags.
   typedef enum logic [1:0] {
      ALU_ARITH,
      ALU_LOGIC,
      ALU_ROTATE,
      ALU_INCDEC
   } rstr_alu_kind_type;

   // One ALU result report from the datapath.
   typedef struct packed {
      logic valid;
      rstr_alu_kind_type kind;
      logic [7:0] result;
      logic carry;
      logic aux;
      logic ovf;
      logic rot_carry;
   } rstr_alu_type;

   // Table read request from the sequencer.
   typedef struct packed {
      logic req;
      logic last_page;
      logic [7:0] ptr;
      logic [7:0] dest;
   } rstr_tbl_req_type;

   // Table read phases.
   typedef enum logic [1:0] {
      TBL_IDLE,
      TBL_FETCH,
      TBL_DONE
   } rstr_tbl_state_type;

   // Serial programming phases.
   typedef enum logic [1:0] {
      PRG_COLLECT,
      PRG_READ,
      PRG_LOAD,
      PRG_SHIFT
   } rstr_prg_state_type;

   // Whole state of the core block.
   typedef struct packed {
      logic [STK_DEPTH-1:0][PC_W-1:0] stk;
      logic [LVL_W-1:0] lvl;
      logic [PC_W-1:0] pc;
      logic [PAGE_W-1:0] cur_page;
      logic int_pend;
      logic int_ack;
      logic [FLG_W-1:0] flags;
      rstr_tbl_state_type tbl_state;
      logic [PC_W-1:0] tbl_addr;
      logic [7:0] tbl_dest;
      logic [7:0] tbl_low;
      logic tbl_we;
      logic [7:0] tbl_high;
      logic [2:0] ck_sync;
      logic [2:0] dt_sync;
      logic ck_level;
      rstr_prg_state_type prg_state;
      logic [4:0] bit_cnt;
      logic [28:0] shreg;
      logic [WORD_W-1:0] out_sh;
      logic drive;
      logic mem_we;
      logic [PC_W-1:0] mem_waddr;
      logic [WORD_W-1:0] mem_wdata;
   } rstr_state_type;

endpackage

// *** verilog/rstr_prog_mem.sv ***
// Program memory: one write port and one read port with registered data.
// Assumes the caller holds its clock enable low to freeze the array.
`timescale 1ns/1ps
module rstr_prog_mem
   import rstr_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 16
)
(
   // Clock and enable.
   input wire logic ref_clk,
   input wire logic clk_en,
   // Write port.
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [DATA_W-1:0] wdata,
   // Read port.
   input wire logic [ADDR_W-1:0] raddr,
   output logic [DATA_W-1:0] rdata
);

   // The storage array; contents are undefined until programmed.
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Read before write; a read of the written word sees old data.
   always_ff @(posedge ref_clk)
   begin
      if (clk_en)
      begin
         if (we)
         begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end

endmodule

// *** verilog/rstr_core.sv ***
// Return stack, program counter, status flags and table read unit.
// Assumes the sequencer gives one-cycle requests and obeys the busy output.
`timescale 1ns/1ps
module rstr_core
   import rstr_pkg::*;
#(
   parameter logic [PC_W-1:0] INT_VECTOR = 12'h004,
   parameter int PROG_WORD_BITS = 16
)
(
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Program flow requests from the sequencer.
   input wire logic pc_step,
   input wire logic jump_req,
   input wire logic [PC_W-1:0] jump_addr,
   input wire logic pcl_write,
   input wire logic [7:0] pcl_data,
   input wire logic call_req,
   input wire logic [PC_W-1:0] call_addr,
   input wire logic subroutine_return,
   input wire logic interrupt_return,
   input wire logic int_event,
   // Program counter, fetched word and interrupt answer.
   output logic [PC_W-1:0] pc,
   output logic [WORD_W-1:0] fetch_word,
   output logic int_pending,
   output logic int_ack,
   output logic stack_full,
   // ALU report and status flags.
   input wire rstr_alu_type alu,
   output logic [FLG_W-1:0] status_flags,
   // Table read request and results.
   input wire rstr_tbl_req_type tbl,
   output logic tbl_busy,
   output logic tbl_low_we,
   output logic [7:0] tbl_low_dest,
   output logic [7:0] tbl_low_data,
   output logic [7:0] table_high_byte,
   // Serial programming pins.
   input wire logic prog_mode,
   input wire logic program_serial_clock,
   input wire logic program_serial_data_in,
   output logic program_serial_data_out,
   output logic program_serial_data_oe
);

   // Implemented bits of the high byte of a program word.
   localparam logic [7:0] HIGH_MASK = 8'(((1 << PROG_WORD_BITS) - 1) >> 8);

   // Current state and its next value.
   rstr_state_type st_reg;
   rstr_state_type st_next;

   // Registered read data from program memory.
   logic [WORD_W-1:0] mem_rdata;
   // Read address chosen for the memory this cycle.
   logic [PC_W-1:0] mem_raddr;
   // Either return instruction.
   logic ret_any;
   // A synchronised rising edge of the programming clock.
   logic ck_rise;
   // Stack full decode.
   logic full;
   // Shift register after taking one more serial bit.
   logic [28:0] sh_new;

   assign ret_any = subroutine_return | interrupt_return;
   assign full = (st_reg.lvl == LVL_FULL);
   assign ck_rise = (st_reg.ck_sync[1] == st_reg.ck_sync[2])
                    && st_reg.ck_sync[2] && !st_reg.ck_level;
   assign sh_new = {st_reg.shreg[27:0], st_reg.dt_sync[2]};

   // Read address: programming first, then table fetch, else the PC.
   always_comb
   begin
      if (st_reg.prg_state == PRG_READ)
      begin
         mem_raddr = st_reg.shreg[PC_W-1:0];
      end
      else if (st_reg.tbl_state == TBL_FETCH)
      begin
         mem_raddr = st_reg.tbl_addr;
      end
      else
      begin
         mem_raddr = st_reg.pc;
      end
   end

   // Program memory; the stack lives apart from it and from data space.
   rstr_prog_mem #(
      .ADDR_W(PC_W),
      .DATA_W(WORD_W)
   ) u_mem (
      .ref_clk(ref_clk),
      .clk_en(clk_en),
      .we(st_reg.mem_we),
      .waddr(st_reg.mem_waddr),
      .wdata(st_reg.mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // Next-state logic for stack, PC, flags, table read and programming.
   always_comb
   begin
      st_next = st_reg;
      st_next.int_ack = 1'b0;
      st_next.tbl_we = 1'b0;
      st_next.mem_we = 1'b0;

      // Program counter stepping and jumps.
      if (pc_step)
      begin
         st_next.cur_page = st_reg.pc[PC_W-1:8];
         st_next.pc = st_reg.pc + 12'h001;
      end
      if (jump_req)
      begin
         st_next.pc = jump_addr;
      end
      if (pcl_write)
      begin
         // Only the low byte moves, so the jump stays in the page.
         st_next.pc = {st_reg.pc[PC_W-1:8], pcl_data};
      end

      // Return pops first; a call in the same cycle is not expected.
      if (ret_any && st_reg.lvl != LVL_EMPTY)
      begin
         st_next.pc = st_reg.stk[st_reg.lvl - 3'h1];
         st_next.lvl = st_reg.lvl - 3'h1;
      end
      else if (call_req)
      begin
         st_next.pc = call_addr;
         if (full)
         begin
            // Oldest entry falls out of the bottom.
            for (int i = 0; i < STK_DEPTH - 1; i++)
            begin
               st_next.stk[i] = st_reg.stk[i+1];
            end
            st_next.stk[STK_DEPTH-1] = st_reg.pc;
         end
         else
         begin
            st_next.stk[st_reg.lvl] = st_reg.pc;
            st_next.lvl = st_reg.lvl + 3'h1;
         end
      end
      else if (st_reg.int_pend && !full && !jump_req && !pcl_write
               && st_reg.tbl_state == TBL_IDLE)
      begin
         // Acknowledge only with a free level; the push saves the PC and the PC takes the vector.
         st_next.int_ack = 1'b1;
         st_next.stk[st_reg.lvl] = st_reg.pc;
         st_next.lvl = st_reg.lvl + 3'h1;
         st_next.pc = INT_VECTOR;
      end

      // Pending flag: a new event wins over the clear by acknowledge.
      if (st_next.int_ack)
      begin
         st_next.int_pend = 1'b0;
      end
      if (int_event)
      begin
         st_next.int_pend = 1'b1;
      end

      // Flag update depends on the kind of operation.
      if (alu.valid)
      begin
         st_next.flags[FLG_Z] = (alu.result == 8'h00);
         unique case (alu.kind)
            ALU_ARITH:
            begin
               st_next.flags[FLG_C] = alu.carry;
               st_next.flags[FLG_AC] = alu.aux;
               st_next.flags[FLG_OV] = alu.ovf;
            end
            ALU_ROTATE:
            begin
               st_next.flags[FLG_Z] = st_reg.flags[FLG_Z];
               if (alu.rot_carry)
               begin
                  st_next.flags[FLG_C] = alu.carry;
               end
            end
            ALU_LOGIC, ALU_INCDEC:
            begin
            end
         endcase
      end

      // Table read: request, fetch cycle, write cycle.
      unique case (st_reg.tbl_state)
         TBL_IDLE:
         begin
            if (tbl.req)
            begin
               st_next.tbl_state = TBL_FETCH;
               st_next.tbl_dest = tbl.dest;
               if (tbl.last_page)
               begin
                  st_next.tbl_addr = {LAST_PAGE, tbl.ptr};
               end
               else
               begin
                  st_next.tbl_addr = {st_reg.cur_page, tbl.ptr};
               end
            end
         end
         TBL_FETCH:
         begin
            st_next.tbl_state = TBL_DONE;
         end
         TBL_DONE:
         begin
            st_next.tbl_state = TBL_IDLE;
            st_next.tbl_we = 1'b1;
            st_next.tbl_low = mem_rdata[7:0];
            st_next.tbl_high = mem_rdata[15:8] & HIGH_MASK;
         end
      endcase

      // Pin synchronisers; the clock's second and third stages are compared downstream.
      st_next.ck_sync = {st_reg.ck_sync[1:0], program_serial_clock};
      st_next.dt_sync = {st_reg.dt_sync[1:0], program_serial_data_in};
      if (st_reg.ck_sync[1] == st_reg.ck_sync[2])
      begin
         st_next.ck_level = st_reg.ck_sync[2];
      end

      // Serial programming on one data pin, clocked from outside.
      if (!prog_mode)
      begin
         st_next.prg_state = PRG_COLLECT;
         st_next.bit_cnt = 5'h00;
         st_next.drive = 1'b0;
      end
      else
      begin
         unique case (st_reg.prg_state)
            PRG_COLLECT:
            begin
               if (ck_rise)
               begin
                  st_next.shreg = sh_new;
                  st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                  if (st_next.bit_cnt == PRG_RD_BITS && !sh_new[12])
                  begin
                     st_next.prg_state = PRG_READ;
                  end
                  else if (st_next.bit_cnt == PRG_WR_BITS)
                  begin
                     st_next.mem_we = 1'b1;
                     st_next.mem_waddr = sh_new[27:16];
                     st_next.mem_wdata = sh_new[15:0];
                     st_next.bit_cnt = 5'h00;
                  end
               end
            end
            PRG_READ:
            begin
               st_next.prg_state = PRG_LOAD;
            end
            PRG_LOAD:
            begin
               st_next.out_sh = mem_rdata;
               st_next.drive = 1'b1;
               st_next.bit_cnt = 5'h00;
               st_next.prg_state = PRG_SHIFT;
            end
            PRG_SHIFT:
            begin
               if (ck_rise)
               begin
                  st_next.out_sh = {st_reg.out_sh[14:0], 1'b0};
                  st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                  if (st_next.bit_cnt == PRG_OUT_BITS)
                  begin
                     st_next.drive = 1'b0;
                     st_next.bit_cnt = 5'h00;
                     st_next.prg_state = PRG_COLLECT;
                  end
               end
            end
         endcase
      end
   end

   // State register with synchronous reset and clock enable.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         st_reg <= '0;
         st_reg.lvl <= LVL_EMPTY;
         st_reg.pc <= PC_RESET;
         st_reg.flags <= FLG_RESET;
         st_reg.tbl_state <= TBL_IDLE;
         st_reg.prg_state <= PRG_COLLECT;
      end
      else if (clk_en)
      begin
         st_reg <= st_next;
      end
   end

   // Outputs; the stack itself and its level have no read path.
   assign pc = st_reg.pc;
   assign fetch_word = mem_rdata;
   assign int_pending = st_reg.int_pend;
   assign int_ack = st_reg.int_ack;
   assign stack_full = full;
   assign status_flags = st_reg.flags;
   assign tbl_busy = (st_reg.tbl_state != TBL_IDLE);
   assign tbl_low_we = st_reg.tbl_we;
   assign tbl_low_dest = st_reg.tbl_dest;
   assign tbl_low_data = st_reg.tbl_low;
   assign table_high_byte = st_reg.tbl_high;
   assign program_serial_data_out = st_reg.out_sh[15];
   assign program_serial_data_oe = st_reg.drive;

   // A quiet cycle: no call, return, jump, low-byte write or table read; an interrupt acknowledge can still push.
   sequence quiet_s;
      !call_req && !ret_any && !jump_req && !pcl_write && !tbl_busy;
   endsequence

   // A return taken while the stack is full and an interrupt waits.
   sequence full_ret_s;
      full && st_reg.int_pend && ret_any && !call_req;
   endsequence

   // Table read accepted from idle.
   sequence tbl_start_s;
      tbl.req && !tbl_busy;
   endsequence

   stack_depth_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      st_reg.lvl <= LVL_FULL)
      else $error("Stack level above six.");

   push_level_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      call_req && !ret_any && !full
      |=> st_reg.lvl == $past(st_reg.lvl) + 3'h1
          && st_reg.stk[$past(st_reg.lvl)] == $past(st_reg.pc))
      else $error("Call did not push the program counter.");

   pop_restore_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      ret_any && st_reg.lvl != LVL_EMPTY
      |=> pc == $past(st_reg.stk[st_reg.lvl - 3'h1]))
      else $error("Return did not restore the saved value.");

   reset_empty_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> st_reg.lvl == LVL_EMPTY && !int_ack)
      else $error("Stack not empty after reset.");

   full_noack_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      full && !ret_any && int_event |=> !int_ack && int_pending)
      else $error("Interrupt acknowledged on a full stack.");

   held_ack_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      full_ret_s ##1 quiet_s |=> int_ack && pc == INT_VECTOR)
      else $error("Held interrupt not serviced after return.");

   overflow_drop_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      call_req && full && !ret_any
      |=> full && st_reg.stk[STK_DEPTH-1] == $past(st_reg.pc)
          && st_reg.stk[0] == $past(st_reg.stk[1]))
      else $error("Full-stack call did not drop the oldest entry.");

   carry_update_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      alu.valid && alu.kind == ALU_ARITH
      |=> status_flags[FLG_C] == $past(alu.carry)
          && status_flags[FLG_Z] == ($past(alu.result) == 8'h00))
      else $error("Arithmetic flags not updated.");

   tbl_two_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      tbl_start_s |=> tbl_busy [*2] ##1 (tbl_low_we && !tbl_busy))
      else $error("Table read not two cycles long.");

   high_zero_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (table_high_byte & ~HIGH_MASK) == 8'h00)
      else $error("Unimplemented table-high bit set.");

   high_only_tbl_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $changed(table_high_byte) |-> tbl_low_we)
      else $error("Table-high changed outside a table read.");

   last_page_a: assert property (
      @(posedge ref_clk) disable iff (!resetn || !clk_en)
      (tbl_start_s and tbl.last_page)
      |=> st_reg.tbl_addr == {LAST_PAGE, $past(tbl.ptr)})
      else $error("Last-page table address wrong.");

endmodule

// *** dv/rstr_prog_host.sv ***
// Serial programmer model that writes program memory words.
// Assumes the bench holds start high until done rises.
`timescale 1ns/1ps
module rstr_prog_host
   import rstr_pkg::*;
(
   // Clock.
   input wire logic ref_clk,
   // Frame request from the bench.
   input wire logic start,
   input wire logic [PC_W-1:0] addr,
   input wire logic [WORD_W-1:0] data,
   input wire logic rd,
   output logic done,
   output logic [WORD_W-1:0] rdata,
   // Serial pins towards the device.
   output logic program_serial_clock,
   output logic program_serial_data,
   // Device side of the shared data line.
   input wire logic program_serial_data_out,
   input wire logic program_serial_data_oe
);
   // Bits of the current read or write frame.
   logic [28:0] frame;
   initial
   begin
      done = 1'b0;
      rdata = 16'h0000;
      program_serial_clock = 1'b0;
      program_serial_data = 1'b0;
   end
   // Sends a frame MSB first; the clock stands low between frames.
   always
   begin
      @(posedge ref_clk iff start);
      frame = rd ? {16'h0000, 1'b0, addr} : {1'b1, addr, data};
      for (int i = rd ? 12 : 28; i >= 0; i--)
      begin
         #1 program_serial_data = frame[i];
         repeat (4) @(posedge ref_clk);
         #1 program_serial_clock = 1'b1;
         repeat (4) @(posedge ref_clk);
         #1 program_serial_clock = 1'b0;
      end
      // A released line must not keep showing the last bit.
      program_serial_data = ~frame[0];
      // A read frame gets sixteen answer bits, MSB first.
      for (int i = rd ? 15 : -1; i >= 0; i--)
      begin
         repeat (4) @(posedge ref_clk);
         // The shared line shows the device only while it drives.
         #1 rdata[i] = program_serial_data_oe ? program_serial_data_out
            : program_serial_data;
         program_serial_clock = 1'b1;
         repeat (4) @(posedge ref_clk);
         #1 program_serial_clock = 1'b0;
      end
      done = 1'b1;
      @(posedge ref_clk iff !start);
      #1 done = 1'b0;
   end
endmodule

// *** dv/return_stack_table_read_bench.sv ***
// Self-checking bench for the return stack and table read core.
// Assumes the serial programmer model loads memory before table reads.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
      end \
   end
module return_stack_table_read_bench;
   import rstr_pkg::*;
   localparam logic [PC_W-1:0] VEC = 12'h004;
   // Clock, reset and design signals.
   logic ref_clk, resetn, pc_step, jump_req, pcl_write, call_req;
   logic subroutine_return, interrupt_return, int_event, prog_mode;
   logic [PC_W-1:0] jump_addr, call_addr, pc, p_addr;
   logic [7:0] pcl_data, tbl_low_dest, tbl_low_data, table_high_byte;
   logic [WORD_W-1:0] fetch_word, p_data, p_rdata;
   logic int_pending, int_ack, stack_full, tbl_busy, tbl_low_we;
   logic [FLG_W-1:0] status_flags;
   logic p_start, p_done, p_rd, s_clk, s_dat, s_out, s_oe;
   rstr_alu_type alu;
   rstr_tbl_req_type tbl;
   int bad_count = 0;
   int compares = 0;
   // Fourteen implemented bits exercise the zeroed high bits.
   rstr_core #(.INT_VECTOR(VEC), .PROG_WORD_BITS(14)) DUT (
      .ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
      .pc_step(pc_step), .jump_req(jump_req), .jump_addr(jump_addr),
      .pcl_write(pcl_write), .pcl_data(pcl_data), .call_req(call_req),
      .call_addr(call_addr), .subroutine_return(subroutine_return),
      .interrupt_return(interrupt_return), .int_event(int_event),
      .pc(pc), .fetch_word(fetch_word), .int_pending(int_pending),
      .int_ack(int_ack), .stack_full(stack_full), .alu(alu),
      .status_flags(status_flags), .tbl(tbl), .tbl_busy(tbl_busy),
      .tbl_low_we(tbl_low_we), .tbl_low_dest(tbl_low_dest),
      .tbl_low_data(tbl_low_data), .table_high_byte(table_high_byte),
      .prog_mode(prog_mode), .program_serial_clock(s_clk),
      .program_serial_data_in(s_dat), .program_serial_data_out(s_out),
      .program_serial_data_oe(s_oe));
   rstr_prog_host HOST (.ref_clk(ref_clk), .start(p_start),
      .addr(p_addr), .data(p_data), .rd(p_rd), .done(p_done),
      .rdata(p_rdata), .program_serial_clock(s_clk),
      .program_serial_data(s_dat), .program_serial_data_out(s_out),
      .program_serial_data_oe(s_oe));
   // Clock generator.
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Waits n edges and steps just past the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Gives one flow request for a cycle: 0 call, 1 return,
   // 2 interrupt return, 3 jump, 4 interrupt event, 5 step,
   // 6 low-byte write.
   task automatic req(input int k, input logic [PC_W-1:0] a);
      call_addr = a;
      jump_addr = a;
      pcl_data = a[7:0];
      case (k)
         0: call_req = 1'b1;
         1: subroutine_return = 1'b1;
         2: interrupt_return = 1'b1;
         3: jump_req = 1'b1;
         4: int_event = 1'b1;
         6: pcl_write = 1'b1;
         default: pc_step = 1'b1;
      endcase
      tick(1);
      {call_req, subroutine_return, interrupt_return} = 3'h0;
      {jump_req, int_event, pc_step, pcl_write} = 4'h0;
      tick(1);
   endtask
   // Writes, or reads back and checks, one word through the serial model.
   task automatic prog_write(input logic [11:0] a, input logic [15:0] d,
      input logic r);
      p_addr = a;
      p_data = d;
      p_rd = r;
      p_start = 1'b1;
      for (int n = 0; n < 400 && p_done !== 1'b1; n++)
         tick(1);
      `CHK("prog done", 1'b1, p_done)
      if (r)
         `CHK("read word", d, p_rdata)
      `CHK("oe released", 1'b0, s_oe)
      p_start = 1'b0;
      tick(10);
   endtask
   // Runs one table read and checks its timing and results.
   task automatic tbl_read(input logic last, input logic [7:0] ptr,
      input logic [7:0] lo, input logic [7:0] hi);
      tbl = '{1'b1, last, ptr, 8'h42};
      tick(1);
      tbl.req = 1'b0;
      `CHK("busy c1", 1'b1, tbl_busy)
      tick(2);
      `CHK("low we", 1'b1, tbl_low_we)
      `CHK("busy c3", 1'b0, tbl_busy)
      `CHK("low data", lo, tbl_low_data)
      `CHK("low dest", 8'h42, tbl_low_dest)
      `CHK("high byte", hi, table_high_byte)
   endtask
   // Places the flag bits by their package positions.
   function automatic logic [3:0] mkf(logic c, logic ac, logic z, logic ov);
      mkf = 4'h0;
      mkf[FLG_C] = c;
      mkf[FLG_AC] = ac;
      mkf[FLG_Z] = z;
      mkf[FLG_OV] = ov;
   endfunction
   // Reports one ALU result and checks the flags that follow.
   task automatic alu_op(input rstr_alu_kind_type k, input logic [7:0] r,
      input logic [3:0] cao, input logic [3:0] exp);
      alu = '{1'b1, k, r, cao[3], cao[2], cao[1], cao[0]};
      tick(1);
      `CHK("flags", exp, status_flags)
      alu.valid = 1'b0;
      tick(1);
   endtask
   // Fills the stack, holds off an interrupt and overflows it.
   task automatic stack_test();
      logic [PC_W-1:0] want [6];
      req(3, 12'h010);
      for (int i = 0; i < 6; i++)
      begin
         `CHK("full early", 1'b0, stack_full)
         req(0, 12'h100 + 12'(i));
         `CHK("call pc", 12'h100 + 12'(i), pc)
      end
      `CHK("full", 1'b1, stack_full)
      req(4, 12'h000);
      for (int i = 0; i < 3; i++)
      begin
         `CHK("held ack", 1'b0, int_ack)
         `CHK("pending", 1'b1, int_pending)
         tick(1);
      end
      req(1, 12'h000);
      for (int n = 0; n < 3 && int_ack !== 1'b1; n++)
         tick(1);
      `CHK("late ack", 1'b1, int_ack)
      `CHK("vector pc", VEC, pc)
      tick(1);
      req(0, 12'h200);
      want = '{VEC, 12'h104, 12'h103, 12'h102, 12'h101, 12'h100};
      for (int i = 0; i < 6; i++)
      begin
         req(i == 0 ? 2 : 1, 12'h000);
         `CHK("pop pc", want[i], pc)
      end
      req(1, 12'h000);
      `CHK("empty pop", 12'h100, pc)
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Cuts a hung run short.
   initial
   begin
      #200000;
      bad_count++;
      conclude();
   end
   // Main sequence.
   initial
   begin
      {resetn, pc_step, jump_req, pcl_write, call_req} = 5'h0;
      {subroutine_return, interrupt_return, int_event} = 3'h0;
      {prog_mode, p_start, p_rd} = 3'h0;
      jump_addr = 12'h000;
      call_addr = 12'h000;
      pcl_data = 8'h00;
      p_addr = 12'h000;
      p_data = 16'h0000;
      alu = '0;
      tbl = '0;
      tick(10);
      `CHK("reset pc", PC_RESET, pc)
      `CHK("reset full", 1'b0, stack_full)
      `CHK("reset flags", FLG_RESET, status_flags)
      `CHK("reset oe", 1'b0, s_oe)
      resetn = 1'b1;
      tick(1);
      prog_mode = 1'b1;
      prog_write(12'h123, 16'h3a5c, 1'b0);
      prog_write(12'hf06, 16'hffa5, 1'b0);
      prog_write(12'h123, 16'h3a5c, 1'b1);
      prog_mode = 1'b0;
      tick(2);
      tbl_read(1'b1, 8'h06, 8'ha5, 8'h3f);
      req(3, 12'h1f0);
      req(5, 12'h000);
      req(6, 12'h0a7);
      `CHK("pcl jump", 12'h1a7, pc)
      tbl_read(1'b0, 8'h23, 8'h5c, 8'h3a);
      req(3, 12'h123);
      tick(1);
      `CHK("fetch", 16'h3a5c, fetch_word)
      alu_op(ALU_ARITH, 8'h00, 4'he, mkf(1, 1, 1, 1));
      alu_op(ALU_LOGIC, 8'h01, 4'h0, mkf(1, 1, 0, 1));
      alu_op(ALU_ROTATE, 8'h00, 4'h1, mkf(0, 1, 0, 1));
      alu_op(ALU_INCDEC, 8'h00, 4'h0, mkf(0, 1, 1, 1));
      stack_test();
      `CHK("high kept", 8'h3a, table_high_byte)
      conclude();
   end
endmodule
